// file: flash_self_program_pkg.sv
// Constants for the flash self programming control block.
// Assumes a single system clock domain and an asynchronous low reset.
`default_nettype none
package flash_self_program_pkg;
   // ----------------------------------------
   // Modes caught at reset release
   // ----------------------------------------
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PROGRAM = 2'h1;
   localparam logic [1:0] MODE_PROHIBITED = 2'h2;
   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   localparam logic [1:0] OP_ERASE = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_VERIFY = 2'h2;
   localparam logic [1:0] OP_BLANK = 2'h3;
   // ----------------------------------------
   // Vectors and mapping
   // ----------------------------------------
   localparam int ADDR_W = 32;
   localparam logic [31:0] RAM_BASE = 32'h03ff_0000;
   localparam logic [31:0] MI_RAM_OFFSET = 32'h0000_0004;
   localparam int BLOCK_W = 5;
   localparam int SWAP_BIT = 4;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int OP_TIME_US = 10;
   localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
   localparam int CNT_W = 16;
endpackage
`default_nettype wire

// file: op_timer.sv
// Busy timer for one hardware flash operation.
// Assumes start is a one cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
   parameter int CYCLES = flash_self_program_pkg::OP_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic start,
   output var logic busy,
   output var logic done
);
   localparam int W = flash_self_program_pkg::CNT_W;
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic done_ff;
   logic nxt_done;
   logic busy_ff;
   logic nxt_busy;
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_done = 1'b0;
      if (start && cnt_ff == '0)
      begin
         nxt_cnt = W'(CYCLES);
      end
      else if (cnt_ff != '0)
      begin
         nxt_cnt = cnt_ff - W'(1);
         nxt_done = (cnt_ff == W'(1));
      end
      nxt_busy = (nxt_cnt != '0);
   end
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= '0;
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else if (ce)
      begin
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
         busy_ff <= nxt_busy;
      end
   end
   assign busy = busy_ff;
   assign done = done_ff;
endmodule
`default_nettype wire

// file: flash_self_program_control.sv
// Flash self programming control: mode strap, write guard, vectors, swap.
// Assumes pins arrive asynchronously; CPU side signals share mclk.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control #(
   parameter int OP_CYCLES = flash_self_program_pkg::OP_CYCLES
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic mode_write_guard_pin,
   input wire logic aux_mode_pin,
   input wire logic self_prog_enter,
   input wire logic self_prog_exit,
   input wire logic op_req,
   input wire logic [1:0] op_code,
   input wire logic swap_req,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_is_flash,
   input wire logic irq_take,
   input wire logic irq_is_nmi,
   input wire logic [31:0] irq_normal_vec,
   input wire logic [4:0] cpu_block,
   output logic [1:0] boot_mode,
   output logic self_prog_active,
   output logic op_busy,
   output logic op_done,
   output logic op_refused,
   output logic [1:0] op_last,
   output logic fetch_grant,
   output logic fetch_refused,
   output logic [31:0] irq_vec,
   output logic irq_vec_valid,
   output logic boot_swapped,
   output logic [4:0] phys_block
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] guard_sync_ff;
   logic [1:0] aux_sync_ff;
   logic guard_s;
   logic aux_s;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         guard_sync_ff <= 2'h0;
         aux_sync_ff <= 2'h0;
      end
      else if (ce)
      begin
         guard_sync_ff <= {guard_sync_ff[0], mode_write_guard_pin};
         aux_sync_ff <= {aux_sync_ff[0], aux_mode_pin};
      end
   end
   assign guard_s = guard_sync_ff[1];
   assign aux_s = aux_sync_ff[1];

   // ----------------------------------------
   // Mode strap and state machine
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_STRAP = 4'h1,
      ST_NORMAL = 4'h2,
      ST_SELF = 4'h4,
      ST_PROG = 4'h8
   } state_e;
   state_e state_ff;
   state_e nxt_state;
   logic [1:0] mode_ff;
   logic [1:0] nxt_mode;
   logic [1:0] strap_cnt_ff;
   logic [1:0] nxt_strap_cnt;
   logic op_busy_w;
   logic active_ff;
   logic nxt_active;

   function automatic logic [1:0] decode_mode(input logic g, input logic a);
      if (!g)
         decode_mode = flash_self_program_pkg::MODE_NORMAL;
      else if (!a)
         decode_mode = flash_self_program_pkg::MODE_PROGRAM;
      else
         decode_mode = flash_self_program_pkg::MODE_PROHIBITED;
   endfunction

   always_comb
   begin
      nxt_state = state_ff;
      nxt_mode = mode_ff;
      nxt_strap_cnt = strap_cnt_ff;
      case (state_ff)
         ST_STRAP:
         begin
            // Wait for synchronisers to fill after release
            if (strap_cnt_ff != 2'h2)
            begin
               nxt_strap_cnt = strap_cnt_ff + 2'h1;
            end
            else
            begin
               nxt_mode = decode_mode(guard_s, aux_s);
               if (guard_s && !aux_s)
                  nxt_state = ST_PROG;
               else if (!guard_s)
                  nxt_state = ST_NORMAL;
            end
         end
         ST_NORMAL:
         begin
            if (self_prog_enter)
               nxt_state = ST_SELF;
         end
         ST_SELF:
         begin
            if (self_prog_exit && !op_busy_w)
               nxt_state = ST_NORMAL;
         end
         ST_PROG:
         begin
            nxt_state = ST_PROG;
         end
         default:
         begin
            nxt_state = ST_STRAP;
         end
      endcase
      nxt_active = (nxt_state == ST_SELF);
   end

   // ----------------------------------------
   // Operations, guard, swap
   // ----------------------------------------
   logic op_done_w;
   logic op_start;
   logic in_self;
   logic swap_ff;
   logic nxt_swap;
   logic refused_ff;
   logic nxt_refused;
   logic [1:0] last_ff;
   logic [1:0] nxt_last;

   assign in_self = (state_ff == ST_SELF);
   // Writes and erases need the guard pin high
   assign op_start = in_self && op_req && !op_busy_w &&
      (guard_s || op_code == flash_self_program_pkg::OP_VERIFY ||
       op_code == flash_self_program_pkg::OP_BLANK);

   op_timer #(
      .CYCLES(OP_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .start(op_start),
      .busy(op_busy_w),
      .done(op_done_w)
   );

   always_comb
   begin
      nxt_refused = op_req && !op_start;
      nxt_last = op_start ? op_code : last_ff;
      nxt_swap = swap_ff;
      if (in_self && swap_req && guard_s && !op_busy_w)
         nxt_swap = !swap_ff;
   end

   // ----------------------------------------
   // Fetch gating and vectors
   // ----------------------------------------
   logic grant_ff;
   logic nxt_grant;
   logic fref_ff;
   logic nxt_fref;
   logic [31:0] vec_ff;
   logic [31:0] nxt_vec;
   logic vvalid_ff;
   logic nxt_vvalid;
   logic [4:0] pblk_ff;
   logic [4:0] nxt_pblk;

   always_comb
   begin
      nxt_grant = fetch_req && !(in_self && fetch_is_flash);
      nxt_fref = fetch_req && in_self && fetch_is_flash;
      nxt_vvalid = irq_take;
      nxt_vec = vec_ff;
      if (irq_take)
      begin
         if (!in_self)
            nxt_vec = irq_normal_vec;
         else if (irq_is_nmi)
            nxt_vec = flash_self_program_pkg::RAM_BASE;
         else
            nxt_vec = flash_self_program_pkg::RAM_BASE +
               flash_self_program_pkg::MI_RAM_OFFSET;
      end
      // Swap flips the top block bit
      nxt_pblk = cpu_block ^
         (5'(swap_ff) << flash_self_program_pkg::SWAP_BIT);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= ST_STRAP;
         active_ff <= 1'b0;
         mode_ff <= flash_self_program_pkg::MODE_NORMAL;
         strap_cnt_ff <= 2'h0;
         swap_ff <= 1'b0;
         refused_ff <= 1'b0;
         last_ff <= 2'h0;
         grant_ff <= 1'b0;
         fref_ff <= 1'b0;
         vec_ff <= 32'h0000_0000;
         vvalid_ff <= 1'b0;
         pblk_ff <= 5'h00;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         active_ff <= nxt_active;
         mode_ff <= nxt_mode;
         strap_cnt_ff <= nxt_strap_cnt;
         swap_ff <= nxt_swap;
         refused_ff <= nxt_refused;
         last_ff <= nxt_last;
         grant_ff <= nxt_grant;
         fref_ff <= nxt_fref;
         vec_ff <= nxt_vec;
         vvalid_ff <= nxt_vvalid;
         pblk_ff <= nxt_pblk;
      end
   end

   assign boot_mode = mode_ff;
   assign self_prog_active = active_ff;
   assign op_busy = op_busy_w;
   assign op_done = op_done_w;
   assign op_refused = refused_ff;
   assign op_last = last_ff;
   assign fetch_grant = grant_ff;
   assign fetch_refused = fref_ff;
   assign irq_vec = vec_ff;
   assign irq_vec_valid = vvalid_ff;
   assign boot_swapped = swap_ff;
   assign phys_block = pblk_ff;
endmodule
`default_nettype wire

// file: spc_assertions.sv
// Port checker for the flash self programming control block.
// Assumes ce stays high around operations, fetches and interrupts.
`timescale 1ns/1ps
`default_nettype none
module spc_assertions #(
   parameter int OP_CYCLES = 8
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic mode_write_guard_pin,
   input wire logic op_req,
   input wire logic [1:0] op_code,
   input wire logic irq_take,
   input wire logic irq_is_nmi,
   input wire logic fetch_req,
   input wire logic fetch_is_flash,
   input wire logic [4:0] cpu_block,
   input wire logic self_prog_active,
   input wire logic op_busy,
   input wire logic op_done,
   input wire logic op_refused,
   input wire logic [31:0] irq_vec,
   input wire logic irq_vec_valid,
   input wire logic fetch_refused,
   input wire logic boot_swapped,
   input wire logic [4:0] phys_block
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   int run_ff;
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         run_ff <= 0;
      else
         run_ff <= op_busy ? run_ff + 1 : 0;
   a_nmi_ram_vec: assert property (
      irq_take && irq_is_nmi && self_prog_active |=> irq_vec_valid
      && irq_vec == flash_self_program_pkg::RAM_BASE) else $error("nmi vec");
   a_mi_ram_vec: assert property (
      irq_take && !irq_is_nmi && self_prog_active |=> irq_vec_valid
      && irq_vec == flash_self_program_pkg::RAM_BASE + 32'h4)
      else $error("maskable vec");
   a_flash_fetch_block: assert property (
      fetch_req && fetch_is_flash && self_prog_active |=> fetch_refused)
      else $error("flash fetch not refused");
   a_guard_blocks_write: assert property (
      (!mode_write_guard_pin)[*4] ##0 (op_req && self_prog_active
      && !op_busy && !op_code[1]) |=> op_refused && !op_busy)
      else $error("write ran with guard low");
   a_idle_refuse: assert property (
      op_req && !self_prog_active |=> op_refused)
      else $error("op outside self state not refused");
   a_busy_length: assert property (
      $fell(op_busy) |-> run_ff == OP_CYCLES) else $error("busy length");
   a_done_at_fall: assert property (
      $fell(op_busy) |-> ##[0:1] op_done) else $error("no done pulse");
   a_swap_map: assert property (
      $past(rst_b) && $stable(boot_swapped) |-> phys_block
      == ($past(cpu_block) ^ {boot_swapped, 4'h0})) else $error("block map");
endmodule
bind flash_self_program_control spc_assertions #(.OP_CYCLES(OP_CYCLES))
   chk_i (.mclk, .rst_b, .mode_write_guard_pin, .op_req, .op_code,
   .irq_take, .irq_is_nmi, .fetch_req, .fetch_is_flash, .cpu_block,
   .self_prog_active, .op_busy, .op_done, .op_refused, .irq_vec,
   .irq_vec_valid, .fetch_refused, .boot_swapped, .phys_block);
`default_nettype wire

// file: flash_self_program_control_tb.sv
// Bench for the flash self programming control with a queue scoreboard.
// Assumes the checker is bound; op time shortened to 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb;
   logic mclk = 1'h0, rst_b = 1'h0, ce = 1'h1, op_req = 1'h0;
   logic mode_write_guard_pin = 1'h0, aux_mode_pin = 1'h0;
   logic fetch_req = 1'h0, fetch_is_flash = 1'h0;
   logic irq_take = 1'h0, irq_is_nmi = 1'h0;
   logic [2:0] ctl = 3'h0;
   logic [1:0] op_code = 2'h0, boot_mode, op_last;
   logic [31:0] fetch_addr = 32'h0, irq_normal_vec = 32'h0, irq_vec;
   logic [4:0] cpu_block = 5'h0, phys_block;
   logic self_prog_active, op_busy, op_done, op_refused, fetch_grant;
   logic fetch_refused, irq_vec_valid, boot_swapped;
   logic [31:0] seed = 32'h0000_25f0;
   logic [31:0] q[$];
   int failures = 0, checks = 0, cyc = 0;
   flash_self_program_control #(.OP_CYCLES(8)) dut (.mclk, .rst_b, .ce,
      .mode_write_guard_pin, .aux_mode_pin, .self_prog_enter(ctl[0]),
      .self_prog_exit(ctl[1]), .swap_req(ctl[2]), .op_req, .op_code,
      .fetch_req, .fetch_addr, .fetch_is_flash, .irq_take, .irq_is_nmi,
      .irq_normal_vec, .cpu_block, .boot_mode, .self_prog_active, .op_busy,
      .op_done, .op_refused, .op_last, .fetch_grant, .fetch_refused,
      .irq_vec, .irq_vec_valid, .boot_swapped, .phys_block);
   always #2.5 mclk = ~mclk;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         failures++;
         $display("FAIL %s exp %h seen %h", n, e, s);
      end
   endtask
   task take(input string n, input logic [31:0] s);
      chk(n, s, q.size() > 0 ? q.pop_front() : 32'hx);
   endtask
   task boot(input logic g, input logic a);
      rst_b = 1'h0;
      mode_write_guard_pin = g;
      aux_mode_pin = a;
      repeat (8) @(negedge mclk);
      rst_b = 1'h1;
      repeat (8) @(negedge mclk);
   endtask
   task pulse(input logic [2:0] v);
      ctl = v;
      @(negedge mclk);
      ctl = 3'h0;
      repeat (2) @(negedge mclk);
   endtask
   task op(input logic [1:0] c, input int n);
      op_code = c;
      op_req = 1'h1;
      repeat (n) @(negedge mclk);
      op_req = 1'h0;
      for (int i = 0; i < 40 && op_busy !== 1'h0; i++)
         @(negedge mclk);
      repeat (2) @(negedge mclk);
   endtask
   task irq(input logic nmi, input logic [31:0] e);
      q.push_back(e);
      irq_is_nmi = nmi;
      irq_take = 1'h1;
      @(negedge mclk);
      irq_take = 1'h0;
      @(negedge mclk);
   endtask
   task fetch(input logic fl, input logic [31:0] e);
      q.push_back(e);
      fetch_addr = rnd();
      fetch_is_flash = fl;
      fetch_req = 1'h1;
      @(negedge mclk);
      fetch_req = 1'h0;
      @(negedge mclk);
   endtask
   always @(negedge mclk)
      if (rst_b)
      begin
         if (irq_vec_valid !== 1'h0)
            take("irq_vec", irq_vec);
         if ((fetch_grant | fetch_refused) !== 1'h0)
            take("fetch", {30'h0, fetch_grant, fetch_refused});
         if ((op_done | op_refused) !== 1'h0)
            take("op", {28'h0, op_done, op_refused, op_last});
      end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         tally_and_finish();
      end
   end
   initial
   begin
      boot(1'h0, 1'h1);
      chk("mode", 32'(boot_mode),
         32'(flash_self_program_pkg::MODE_NORMAL));
      irq_normal_vec = rnd();
      irq(1'h0, irq_normal_vec);
      fetch(1'h1, 32'h2);
      q.push_back(32'h4);
      op(flash_self_program_pkg::OP_VERIFY, 1);
      pulse(3'h1);
      chk("active", 32'(self_prog_active), 32'h1);
      q.push_back(32'h4);
      op(flash_self_program_pkg::OP_WRITE, 1);
      q.push_back(32'ha);
      op(flash_self_program_pkg::OP_VERIFY, 1);
      fetch(1'h1, 32'h1);
      fetch(1'h0, 32'h2);
      irq(1'h1, flash_self_program_pkg::RAM_BASE);
      irq(1'h0, flash_self_program_pkg::RAM_BASE + 32'h4);
      mode_write_guard_pin = 1'h1;
      repeat (4) @(negedge mclk);
      ce = 1'h1;
      for (int c = 0; c < 4; c++)
      begin
         q.push_back(32'h4 | c);
         q.push_back(32'h8 | c);
         op(2'(c), 2);
      end
      cpu_block = 5'(rnd());
      pulse(3'h4);
      chk("swapped", 32'(boot_swapped), 32'h1);
      chk("block", 32'(phys_block), 32'(cpu_block ^ 5'h10));
      pulse(3'h4);
      chk("block", 32'(phys_block), 32'(cpu_block));
      ce = 1'h0;
      pulse(3'h4);
      chk("frozen", 32'(boot_swapped), 32'h0);
      ce = 1'h1;
      pulse(3'h2);
      mode_write_guard_pin = 1'h0;
      chk("active", 32'(self_prog_active), 32'h0);
      boot(1'h1, 1'h0);
      chk("mode", 32'(boot_mode),
         32'(flash_self_program_pkg::MODE_PROGRAM));
      boot(1'h1, 1'h1);
      chk("mode", 32'(boot_mode),
         32'(flash_self_program_pkg::MODE_PROHIBITED));
      chk("queue", q.size(), 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
